// File: cmf_clock_mux_fanout_gate.sv
`timescale 1ns/1ns
`include "cmf_defs.svh"

// How it works
// - All five output pairs carry one identical buffered copy of the selected clock.
// - Source choice low routes pair a, high routes pair b; the other pair is ignored.
// - A source choice that nobody drives counts as high, so pair b is the default.
// - Each true output follows the selected true line and each complement is its inverse.
// - Gate high enables all outputs; gate low forces true outputs low, complements high.
// - A gate change applies only after a rising then a falling edge of the selected clock.
// - A gate input that nobody drives counts as high, so outputs are on by default.
// - A selected input that stops toggling or loses its swing is detected as invalid.

module cmf_clock_mux_fanout_gate #(
   parameter int FANOUT_NUM  = `CMF_FANOUT_NUM,
   parameter int DEAD_CYCLES = `CMF_DEAD_CYCLES
) (
   input  wire logic                  ref_clk,
   input  wire logic                  reset,
   input  wire cmf_pkg::cmf_pair_type clock_in_a,
   input  wire cmf_pkg::cmf_pair_type clock_in_b,
   input  wire cmf_pkg::cmf_ctrl_type source_choice,
   input  wire cmf_pkg::cmf_ctrl_type output_gate,
   output logic [FANOUT_NUM-1:0]      fanout_pairs_p,
   output logic [FANOUT_NUM-1:0]      fanout_pairs_n,
   output logic                       dead_input_guard_q
);

   // ==========================================================
   // module state
   typedef struct packed {
      cmf_pkg::cmf_pair_type      a;
      cmf_pkg::cmf_pair_type      b;
      logic                       sel;
      logic                       gate_req;
      logic                       prev_true;
      logic                       gate_on;
      cmf_pkg::cmf_gate_state_type gate_st;
      logic [FANOUT_NUM-1:0]      out_p;
      logic [FANOUT_NUM-1:0]      out_n;
   } cmf_top_state_type;

   cmf_top_state_type     st_q;
   cmf_top_state_type     st_d;
   cmf_pkg::cmf_pair_type sel_pair;
   logic                  dead;
   logic                  sel_rise;
   logic                  sel_fall;

   // resolve an open control to its pull-up level
   function automatic logic cmf_resolve(input cmf_pkg::cmf_ctrl_type c, input logic open_lvl);
      cmf_resolve = c.driven ? c.level : open_lvl;
   endfunction : cmf_resolve

   // ==========================================================
   // selected pair and its edges
   assign sel_pair = st_q.sel ? st_q.b : st_q.a;
   assign sel_rise = sel_pair.p && !st_q.prev_true;
   assign sel_fall = !sel_pair.p && st_q.prev_true;

   cmf_dead_input_guard #(
      .DEAD_CYCLES (DEAD_CYCLES)
   ) u_guard (
      .ref_clk (ref_clk),
      .reset   (reset),
      .pair    (sel_pair),
      .dead_q  (dead)
   );

   // ==========================================================
   // next state
   always_comb begin
      st_d           = st_q;
      st_d.a         = clock_in_a;
      st_d.b         = clock_in_b;
      st_d.sel       = cmf_resolve(source_choice, `CMF_SEL_OPEN_LEVEL);
      st_d.gate_req  = cmf_resolve(output_gate, `CMF_GATE_OPEN_LEVEL);
      st_d.prev_true = sel_pair.p;

      // gate change waits for a full rise-then-fall so no pulse is cut short
      case (st_q.gate_st)
         cmf_pkg::CMF_GATE_STEADY: begin
            if (st_q.gate_req != st_q.gate_on) begin
               st_d.gate_st = cmf_pkg::CMF_GATE_WAIT_RISE;
            end
         end
         cmf_pkg::CMF_GATE_WAIT_RISE: begin
            if (st_q.gate_req == st_q.gate_on) begin
               st_d.gate_st = cmf_pkg::CMF_GATE_STEADY;
            end else if (sel_rise) begin
               st_d.gate_st = cmf_pkg::CMF_GATE_WAIT_FALL;
            end
         end
         cmf_pkg::CMF_GATE_WAIT_FALL: begin
            if (st_q.gate_req == st_q.gate_on) begin
               st_d.gate_st = cmf_pkg::CMF_GATE_STEADY;
            end else if (sel_fall) begin
               st_d.gate_on = st_q.gate_req;
               st_d.gate_st = cmf_pkg::CMF_GATE_STEADY;
            end
         end
         default: begin
            st_d.gate_st = cmf_pkg::CMF_GATE_STEADY;
         end
      endcase

      // fanout copy, forced idle when gated off or input dead
      if (st_q.gate_on && !dead) begin
         st_d.out_p = {FANOUT_NUM{sel_pair.p}};
         st_d.out_n = {FANOUT_NUM{!sel_pair.p}};
      end else begin
         st_d.out_p = {FANOUT_NUM{`CMF_TRUE_IDLE}};
         st_d.out_n = {FANOUT_NUM{`CMF_COMP_IDLE}};
      end
   end

   // ==========================================================
   // registers; reset comes up enabled with pair b chosen, as when pins float
   always_ff @(posedge ref_clk or posedge reset) begin
      if (reset) begin
         st_q.a         <= '{p: 1'b0, n: 1'b1};
         st_q.b         <= '{p: 1'b0, n: 1'b1};
         st_q.sel       <= `CMF_SEL_OPEN_LEVEL;
         st_q.gate_req  <= `CMF_GATE_OPEN_LEVEL;
         st_q.prev_true <= 1'b0;
         st_q.gate_on   <= `CMF_GATE_OPEN_LEVEL;
         st_q.gate_st   <= cmf_pkg::CMF_GATE_STEADY;
         st_q.out_p     <= {FANOUT_NUM{`CMF_TRUE_IDLE}};
         st_q.out_n     <= {FANOUT_NUM{`CMF_COMP_IDLE}};
      end else begin
         st_q <= st_d;
      end
   end

   // outputs straight from flip-flops
   assign fanout_pairs_p     = st_q.out_p;
   assign fanout_pairs_n     = st_q.out_n;
   assign dead_input_guard_q = dead;

   // ==========================================================
   // checks
   sequence s_rise_seen;
      (st_q.gate_st == cmf_pkg::CMF_GATE_WAIT_FALL);
   endsequence

   sequence s_fall_now;
      sel_fall;
   endsequence

   sequence s_waiting_rise;
      (st_q.gate_st == cmf_pkg::CMF_GATE_WAIT_RISE);
   endsequence

   sequence s_gate_pending;
      (st_q.gate_st == cmf_pkg::CMF_GATE_STEADY) && (st_q.gate_req != st_q.gate_on);
   endsequence

   chk_pairs_identical: assert property (@(posedge ref_clk) disable iff (reset)
      (st_q.out_p == '0) || (st_q.out_p == '1))
      else $error("output pairs differ");

   // expectation built from the registered pairs, not from the mux itself
   chk_route_a_b: assert property (@(posedge ref_clk) disable iff (reset)
      (st_q.gate_on && !dead) |=>
         (st_q.out_p[0] == ($past(st_q.sel) ? $past(st_q.b.p) : $past(st_q.a.p))))
      else $error("wrong input routed");

   // a driven select pin is taken with one edge of latency
   chk_sel_from_pin: assert property (@(posedge ref_clk) disable iff (reset)
      source_choice.driven |=> (st_q.sel == $past(source_choice.level)))
      else $error("driven select not taken");

   // every bit of the copy equals the selected true line of the cycle before
   chk_copy_all_bits: assert property (@(posedge ref_clk) disable iff (reset)
      (st_q.gate_on && !dead) |=> (st_q.out_p == {FANOUT_NUM{$past(sel_pair.p)}}))
      else $error("copy differs from selected line");

   chk_open_select: assert property (@(posedge ref_clk) disable iff (reset)
      !source_choice.driven |=> st_q.sel)
      else $error("open select not high");

   chk_complement: assert property (@(posedge ref_clk) disable iff (reset)
      st_q.out_n == ~st_q.out_p)
      else $error("complement not inverse");

   chk_gate_off_idle: assert property (@(posedge ref_clk) disable iff (reset)
      !st_q.gate_on |=> (st_q.out_p == '0) && (st_q.out_n == '1))
      else $error("gated outputs not idle");

   chk_gate_after_edges: assert property (@(posedge ref_clk) disable iff (reset)
      (st_q.gate_on != st_d.gate_on) |-> s_rise_seen and s_fall_now)
      else $error("gate applied without rise and fall");

   // a new request arms the wait and leaves the gate alone for now
   chk_gate_arms: assert property (@(posedge ref_clk) disable iff (reset)
      s_gate_pending |=> (st_q.gate_st == cmf_pkg::CMF_GATE_WAIT_RISE) &&
         $stable(st_q.gate_on))
      else $error("gate request not armed");

   // no rising edge seen yet, so the gate must not move
   chk_gate_waits_rise: assert property (@(posedge ref_clk) disable iff (reset)
      s_waiting_rise |=> $stable(st_q.gate_on))
      else $error("gate moved before a rising edge");

   // a reverted request cancels the wait with the gate unchanged
   chk_gate_cancel: assert property (@(posedge ref_clk) disable iff (reset)
      ((st_q.gate_st != cmf_pkg::CMF_GATE_STEADY) && (st_q.gate_req == st_q.gate_on)) |=>
         (st_q.gate_st == cmf_pkg::CMF_GATE_STEADY) && $stable(st_q.gate_on))
      else $error("reverted gate request not cancelled");

   // after a rise then a fall the gate holds what was requested
   chk_gate_applies: assert property (@(posedge ref_clk) disable iff (reset)
      (s_rise_seen and s_fall_now) |=> (st_q.gate_on == $past(st_q.gate_req)))
      else $error("gate not applied after rise and fall");

   // a selected pair with no swing is flagged one edge later
   chk_flat_flagged: assert property (@(posedge ref_clk) disable iff (reset)
      (sel_pair.p == sel_pair.n) |=> dead)
      else $error("flat selected pair not flagged");

   chk_open_gate: assert property (@(posedge ref_clk) disable iff (reset)
      !output_gate.driven |=> st_q.gate_req)
      else $error("open gate not high");

   chk_dead_idle: assert property (@(posedge ref_clk) disable iff (reset)
      dead |=> (st_q.out_p == '0) && (st_q.out_n == '1))
      else $error("dead input reached outputs");

endmodule : cmf_clock_mux_fanout_gate

// File: cmf_clock_mux_fanout_gate_tb.sv
`timescale 1ns/1ns

module cmf_clock_mux_fanout_gate_tb;
   localparam int HA   = 3;
   localparam int HB   = 5;
   localparam int DEAD = 8;

   logic                  ref_clk       = 1'h0;
   logic                  reset         = 1'h1;
   logic [1:0]            mode_a        = 2'h0;
   logic [1:0]            mode_b        = 2'h0;
   cmf_pkg::cmf_pair_type clock_in_a;
   cmf_pkg::cmf_pair_type clock_in_b;
   cmf_pkg::cmf_ctrl_type source_choice = '{driven: 1'h1, level: 1'h0};
   cmf_pkg::cmf_ctrl_type output_gate   = '{driven: 1'h0, level: 1'h0};
   logic [4:0]            fanout_pairs_p;
   logic [4:0]            fanout_pairs_n;
   logic                  dead_input_guard_q;
   logic [1:0]            hist_q        = 2'h0;
   logic                  mon_on        = 1'h0;
   int                    run_len       = 0;
   int                    mismatches    = 0;
   int                    n_compared    = 0;

   // ==========================================================
   // clock, partners and block
   always #5 ref_clk = ~ref_clk;

   cmf_clock_source #(.HALF_CYC(HA)) src_a (.ref_clk(ref_clk), .reset(reset), .mode(mode_a),
                                            .pair(clock_in_a));
   cmf_clock_source #(.HALF_CYC(HB)) src_b (.ref_clk(ref_clk), .reset(reset), .mode(mode_b),
                                            .pair(clock_in_b));

   cmf_clock_mux_fanout_gate #(.DEAD_CYCLES(DEAD)) cmf_clock_mux_fanout_gate_inst (
      .ref_clk(ref_clk), .reset(reset), .clock_in_a(clock_in_a), .clock_in_b(clock_in_b),
      .source_choice(source_choice), .output_gate(output_gate),
      .fanout_pairs_p(fanout_pairs_p), .fanout_pairs_n(fanout_pairs_n),
      .dead_input_guard_q(dead_input_guard_q));

   // ==========================================================
   // reference: selected true line as sampled, an open select pin counts high
   always @(posedge ref_clk) begin
      hist_q <= {hist_q[0], (~source_choice.driven | source_choice.level) ? clock_in_b.p
                                                                              : clock_in_a.p};
   end

   // high pulses must stay whole half periods while the gate moves
   always @(posedge ref_clk) begin
      if (fanout_pairs_p[0] === 1'h1) begin
         run_len <= run_len + 1;
      end else begin
         if (mon_on && run_len != 0) check_int(run_len, HA, "pulse width");
         run_len <= 0;
      end
   end

   // ==========================================================
   // compares and shared steps
   task automatic check_bits(input logic [4:0] got, input logic [4:0] exp, input string what);
      n_compared++;
      if (got !== exp) begin
         mismatches++;
         $display("BAD %0t %s got %h exp %h", $time, what, got, exp);
      end
   endtask : check_bits

   task automatic check_int(input int got, input int exp, input string what);
      n_compared++;
      if (got != exp) begin
         mismatches++;
         $display("BAD %0t %s got %0d exp %0d", $time, what, got, exp);
      end
   endtask : check_int

   // the line sampled at one edge shows on the outputs after the next edge
   task automatic check_follow(input int cycles);
      repeat (cycles) begin
         @(negedge ref_clk);
         check_bits(fanout_pairs_p, {5{hist_q[1]}}, "copy");
         check_bits(fanout_pairs_n, ~{5{hist_q[1]}}, "complement");
      end
   endtask : check_follow

   task automatic check_idle(input logic dead_exp);
      @(negedge ref_clk);
      check_bits(fanout_pairs_p, 5'h00, "idle true");
      check_bits(fanout_pairs_n, 5'h1f, "idle complement");
      check_bits({4'h0, dead_input_guard_q}, {4'h0, dead_exp}, "guard");
   endtask : check_idle

   // ==========================================================
   // scenarios
   task automatic test_select();
      cmf_pkg::cmf_ctrl_type sel_set [3] = '{'{1'h1, 1'h0}, '{1'h1, 1'h1}, '{1'h0, 1'h0}};
      for (int i = 0; i < 3; i++) begin
         @(posedge ref_clk);
         source_choice <= sel_set[i];
         repeat (20) @(posedge ref_clk);
         check_follow(30);
      end
      $display("test select done");
   endtask : test_select

   task automatic test_gate();
      @(posedge ref_clk);
      source_choice <= '{driven: 1'h1, level: 1'h0};
      repeat (20) @(posedge ref_clk);
      mon_on <= 1'h1;
      output_gate <= '{driven: 1'h1, level: 1'h0};
      check_follow(2);
      repeat (4 * HA + 6) @(posedge ref_clk);
      repeat (10) check_idle(1'h0);
      @(posedge ref_clk);
      output_gate <= '{driven: 1'h0, level: 1'h0};
      check_idle(1'h0);
      repeat (4 * HA + 6) @(posedge ref_clk);
      check_follow(20);
      mon_on <= 1'h0;
      $display("test gate done");
   endtask : test_gate

   task automatic test_dead();
      for (int m = 2; m > 0; m--) begin
         @(posedge ref_clk);
         mode_a <= 2'(m);
         repeat (DEAD + 6) @(posedge ref_clk);
         repeat (4) check_idle(1'h1);
         @(posedge ref_clk);
         mode_a <= 2'h0;
         repeat (20) @(posedge ref_clk);
         check_follow(20);
         check_bits({4'h0, dead_input_guard_q}, 5'h00, "guard cleared");
      end
      $display("test dead done");
   endtask : test_dead

   task automatic close_out();
      $display("compared %0d mismatches %0d", n_compared, mismatches);
      if (mismatches == 0 && n_compared > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask : close_out

   // ==========================================================
   // main sequence and watchdog, about 370 cycles expected
   initial begin
      repeat (6) @(posedge ref_clk);
      reset <= 1'h0;
      test_select();
      test_gate();
      test_dead();
      close_out();
   end

   initial begin
      repeat (3000) @(posedge ref_clk);
      mismatches++;
      close_out();
   end
endmodule : cmf_clock_mux_fanout_gate_tb

// File: cmf_clock_source.sv
`timescale 1ns/1ns

// ==========================================================
// upstream differential clock source
// mode 0 toggles every HALF_CYC edges, mode 1 freezes the lines with full swing,
// mode 2 collapses both lines to one dc level so that no swing is left
module cmf_clock_source #(
   parameter int HALF_CYC = 3
) (
   input  wire logic             ref_clk,
   input  wire logic             reset,
   input  wire logic [1:0]       mode,
   output cmf_pkg::cmf_pair_type pair
);
   int cnt_q;

   // all changes land just after the sampling edge, so the block never sees a half-changed pair
   always @(posedge ref_clk or posedge reset) begin
      if (reset) begin
         cnt_q <= 0;
         pair  <= '{p: 1'h0, n: 1'h1};
      end else if (mode == 2'h0) begin
         cnt_q <= (cnt_q == HALF_CYC - 1) ? 0 : cnt_q + 1;
         if (cnt_q == HALF_CYC - 1) begin
            pair <= '{p: ~pair.p, n: pair.p};
         end
      end else if (mode == 2'h2) begin
         pair <= '{p: 1'h0, n: 1'h0};
      end
   end
endmodule : cmf_clock_source

// File: cmf_dead_input_guard.sv
`timescale 1ns/1ns
`include "cmf_defs.svh"

module cmf_dead_input_guard #(
   parameter int DEAD_CYCLES = `CMF_DEAD_CYCLES
) (
   input  wire logic                  ref_clk,
   input  wire logic                  reset,
   input  wire cmf_pkg::cmf_pair_type pair,
   output logic                       dead_q
);

   cmf_pkg::cmf_guard_state_type st_q;
   cmf_pkg::cmf_guard_state_type st_d;
   logic                         edge_seen;
   logic                         flat;

   // ==========================================================
   // detection: no swing or no edge for too long
   // p equal to n is the logic image of a swing collapsed to dc
   assign flat      = (pair.p == pair.n);
   assign edge_seen = (pair.p != st_q.prev_true);

   always_comb begin
      st_d           = st_q;
      st_d.prev_true = pair.p;
      if (edge_seen) begin
         st_d.idle_cnt = 16'h0000;
      end else if (st_q.idle_cnt < 16'(DEAD_CYCLES)) begin
         st_d.idle_cnt = st_q.idle_cnt + 16'h0001;
      end
      // flat or stalled input is invalid; a live edge revives it
      if (flat || (!edge_seen && st_q.idle_cnt >= 16'(DEAD_CYCLES - 1))) begin
         st_d.dead = 1'b1;
      end else if (edge_seen) begin
         st_d.dead = 1'b0;
      end
   end

   // start dead so nothing toggles before a real edge arrives
   always_ff @(posedge ref_clk or posedge reset) begin
      if (reset) begin
         st_q <= '{prev_true: 1'b0, idle_cnt: 16'h0000, dead: 1'b1};
      end else begin
         st_q <= st_d;
      end
   end

   assign dead_q = st_q.dead;

   // ==========================================================
   // checks
   chk_flat_is_dead: assert property (@(posedge ref_clk) disable iff (reset)
      (pair.p == pair.n) |=> dead_q)
      else $error("flat input not flagged dead");

   chk_stall_is_dead: assert property (@(posedge ref_clk) disable iff (reset)
      (st_q.idle_cnt == 16'(DEAD_CYCLES)) |-> st_q.dead)
      else $error("stalled input not flagged dead");

endmodule : cmf_dead_input_guard

// File: cmf_defs.svh
`ifndef CMF_DEFS_SVH
`define CMF_DEFS_SVH

// ==========================================================
// clock and timing
`define CMF_CLK_MHZ        100
// a selected input with no true-line edge for this long is dead
`define CMF_DEAD_TIME_NS   1000
`define CMF_DEAD_CYCLES    ((`CMF_DEAD_TIME_NS * `CMF_CLK_MHZ) / 1000)

// ==========================================================
// pull-up levels of the single-ended controls when left open
`define CMF_SEL_OPEN_LEVEL  1'b1
`define CMF_GATE_OPEN_LEVEL 1'b1

// ==========================================================
// fanout width and output reset levels
`define CMF_FANOUT_NUM      5
`define CMF_TRUE_IDLE       1'b0
`define CMF_COMP_IDLE       1'b1

`endif

// File: cmf_pkg.sv
`include "cmf_defs.svh"

package cmf_pkg;

   // ==========================================================
   // one differential input pair, true and complement line
   typedef struct packed {
      logic p;
      logic n;
   } cmf_pair_type;

   // ==========================================================
   // single-ended control that may be left open (pulled up)
   typedef struct packed {
      logic driven;
      logic level;
   } cmf_ctrl_type;

   // ==========================================================
   // gate change tracking against the selected clock
   typedef enum logic [1:0] {
      CMF_GATE_STEADY,
      CMF_GATE_WAIT_RISE,
      CMF_GATE_WAIT_FALL
   } cmf_gate_state_type;

   // ==========================================================
   // state of the dead input guard
   typedef struct packed {
      logic        prev_true;
      logic [15:0] idle_cnt;
      logic        dead;
   } cmf_guard_state_type;

endpackage : cmf_pkg
